/* rtl/hps_pkg.sv */
// constants and types shared by the slot status block
package hps_pkg;

  // ==========================================================
  // register bus
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] SLOT_REG_OFFSET = 12'h0d8;
  localparam logic [11:0] IRQ_STAT_OFFSET = 12'h1f0;
  localparam logic [11:0] IRQ_CLR_OFFSET = 12'h1f4;
  localparam logic [11:0] IRQ_EN_OFFSET = 12'h1f8;

  // ==========================================================
  // slot status field positions within the dword
  localparam int BTN_BIT = 16;
  localparam int FAULT_BIT = 17;
  localparam int LATCH_CHG_BIT = 18;
  localparam int PRES_CHG_BIT = 19;
  localparam int CMD_BIT = 20;
  localparam int LATCH_STATE_BIT = 21;
  localparam int PRES_STATE_BIT = 22;
  localparam int LINK_CHG_BIT = 24;

  // ==========================================================
  // slot control field positions and values (low half-word)
  localparam int CTL_BTN_EN_BIT = 0;
  localparam int CTL_FAULT_EN_BIT = 1;
  localparam int CTL_PRES_EN_BIT = 3;
  localparam int CTL_CMD_EN_BIT = 4;
  localparam int CTL_HP_INT_EN_BIT = 5;
  localparam int CTL_LINK_EN_BIT = 12;
  localparam logic [15:0] CTL_WR_MASK = 16'h17fb;
  localparam logic [15:0] CTL_RESET = 16'h03c0;

  // ==========================================================
  // event indices in the flag banks
  localparam int EV_BTN = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_PRES = 2;
  localparam int EV_CMD = 3;
  localparam int EV_LINK = 4;
  localparam int EV_LATCH = 5;
  localparam int NUM_IRQ = 5;
  localparam int NUM_FLAGS = 6;
  localparam logic [5:0] FLAGS_RESET = 6'h10;
  localparam logic [4:0] IRQ_RESET = 5'h00;

  // ==========================================================
  // presence initialisation phase
  typedef enum logic {
    HPS_INIT_STRAP = 1'b0,
    HPS_INIT_RUN = 1'b1
  } hps_init_t;

endpackage : hps_pkg

/* rtl/hps_flag_bank.sv */
// sticky event flags cleared by writing one
`timescale 1ns/10ps
module hps_flag_bank
  import hps_pkg::*;
#(
  parameter int W = 5,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // events and clears
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clear_in,
  // flags
  output logic [W-1:0] flags_out
);

  logic [W-1:0] flags;
  logic [W-1:0] next_flags;

  // ==========================================================
  // set wins over a clear in the same cycle
  always_comb begin
    next_flags = (flags & ~clear_in) | set_in;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flags <= RESET_VALUE;
    end else begin
      flags <= next_flags;
    end
  end

  assign flags_out = flags;

  a_set_wins: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (set_in != '0) |=> ((flags & $past(set_in)) == $past(set_in)))
    else $error("flag bank lost an event");

endmodule : hps_flag_bank

/* rtl/hps_slot_status.sv */
// slot status register, slot control enables and hot-plug interrupt
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps

// Notes on behaviour
// - the slot status field exists only on downstream ports, in the upper half of the dword at D8h.
// - bit 16 is set by an attention button press and held until software writes one to it.
// - bit 17 is set by a power fault, held until a one is written, and resets to zero.
// - bit 18, the latch change indication, is read-only, ignores writes and resets to zero.
// - bit 19 is set on any change of card presence, cleared by writing one, and resets to zero.
// - bit 20 is set when the controller finishes a command, cleared by writing one, resets to zero.
// - bit 21 mirrors the retention latch, zero closed and one open, and resets to zero.
// - bit 22 reports card presence, zero for empty and one for a card present.
// - with no slot implemented the presence state bit always reads one.
// - the presence state resets to zero when the strap is high and one when it is low.
// - bit 24 is set whenever the link-active indication changes and cleared by writing one.
// - the hot-plug interrupt rises only when the global enable and the event's own enable are set.
// - a completed command raises hp_int_out only when its completion enable is set; on irq_out it is gated by irq_en instead.
module hps_slot_status
  import hps_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  // port configuration
  input wire logic downstream_port_in,
  input wire logic slot_implemented_in,
  input wire logic card_present_strap_in,
  // slot hardware
  input wire logic card_present_in,
  input wire logic retention_latch_open_in,
  input wire logic attn_button_in,
  input wire logic power_fault_in,
  input wire logic cmd_done_in,
  input wire logic link_active_in,
  // interrupts and status
  output logic hp_int_out,
  output logic irq_out,
  output logic hardware_initialized_out
);

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
    hit = (addr == offset);
  endfunction : hit

  // ==========================================================
  // slot sense state
  hps_init_t init_state;
  hps_init_t next_init_state;
  logic presence_state;
  logic next_presence_state;
  logic latch_state;
  logic next_latch_state;
  logic link_prev;
  logic next_link_prev;
  logic running;

  assign running = (init_state == HPS_INIT_RUN);

  always_comb begin
    next_init_state = HPS_INIT_RUN;
    next_latch_state = retention_latch_open_in;
    next_link_prev = link_active_in;
    unique case (init_state)
      HPS_INIT_STRAP: begin
        next_presence_state = ~card_present_strap_in;
      end
      HPS_INIT_RUN: begin
        next_presence_state = card_present_in;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      init_state <= HPS_INIT_STRAP;
      presence_state <= 1'b0;
      latch_state <= 1'b0;
      link_prev <= 1'b0;
    end else begin
      init_state <= next_init_state;
      presence_state <= next_presence_state;
      latch_state <= next_latch_state;
      link_prev <= next_link_prev;
    end
  end

  assign hardware_initialized_out = running;

  // ==========================================================
  // event detection and flag clears
  logic [NUM_FLAGS-1:0] ev_set;
  logic [NUM_FLAGS-1:0] status_clear;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_IRQ-1:0] irq_clear;
  logic [NUM_IRQ-1:0] irq_stat;
  logic slot_wr;

  assign slot_wr = wr_in & downstream_port_in & hit(addr_in, SLOT_REG_OFFSET);

  always_comb begin
    ev_set = '0;
    ev_set[EV_BTN] = downstream_port_in & attn_button_in;
    ev_set[EV_FAULT] = downstream_port_in & power_fault_in;
    ev_set[EV_PRES] = downstream_port_in & running & (card_present_in != presence_state);
    ev_set[EV_CMD] = downstream_port_in & cmd_done_in;
    ev_set[EV_LINK] = downstream_port_in & running & (link_active_in != link_prev);
    ev_set[EV_LATCH] = downstream_port_in & running & (retention_latch_open_in != latch_state);
    status_clear = '0;
    if (slot_wr) begin
      status_clear[EV_BTN] = wdata_in[BTN_BIT];
      status_clear[EV_FAULT] = wdata_in[FAULT_BIT];
      status_clear[EV_PRES] = wdata_in[PRES_CHG_BIT];
      status_clear[EV_CMD] = wdata_in[CMD_BIT];
      status_clear[EV_LINK] = wdata_in[LINK_CHG_BIT];
    end
    irq_clear = '0;
    if (wr_in && hit(addr_in, IRQ_CLR_OFFSET)) begin
      irq_clear = wdata_in[NUM_IRQ-1:0];
    end
  end

  // latch change bit has no clear path: only reset empties it
  hps_flag_bank #(
    .W(NUM_FLAGS),
    .RESET_VALUE(FLAGS_RESET)
  ) u_status_flags (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .set_in(ev_set),
    .clear_in(status_clear),
    .flags_out(flags)
  );

  hps_flag_bank #(
    .W(NUM_IRQ),
    .RESET_VALUE(IRQ_RESET)
  ) u_irq_flags (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .set_in(ev_set[NUM_IRQ-1:0]),
    .clear_in(irq_clear),
    .flags_out(irq_stat)
  );

  // ==========================================================
  // slot control and interrupt enable registers
  logic [15:0] ctl;
  logic [15:0] next_ctl;
  logic [NUM_IRQ-1:0] irq_en;
  logic [NUM_IRQ-1:0] next_irq_en;

  always_comb begin
    next_ctl = ctl;
    next_irq_en = irq_en;
    if (slot_wr) begin
      next_ctl = wdata_in[15:0] & CTL_WR_MASK;
    end
    if (wr_in && hit(addr_in, IRQ_EN_OFFSET)) begin
      next_irq_en = wdata_in[NUM_IRQ-1:0];
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl <= CTL_RESET;
      irq_en <= IRQ_RESET;
    end else begin
      ctl <= next_ctl;
      irq_en <= next_irq_en;
    end
  end

  // ==========================================================
  // interrupt outputs
  logic [NUM_IRQ-1:0] hp_enabled;

  always_comb begin
    hp_enabled = '0;
    hp_enabled[EV_BTN] = ctl[CTL_BTN_EN_BIT] & flags[EV_BTN];
    hp_enabled[EV_FAULT] = ctl[CTL_FAULT_EN_BIT] & flags[EV_FAULT];
    hp_enabled[EV_PRES] = ctl[CTL_PRES_EN_BIT] & flags[EV_PRES];
    hp_enabled[EV_CMD] = ctl[CTL_CMD_EN_BIT] & flags[EV_CMD];
    hp_enabled[EV_LINK] = ctl[CTL_LINK_EN_BIT] & flags[EV_LINK];
  end

  assign hp_int_out = downstream_port_in & ctl[CTL_HP_INT_EN_BIT] & (|hp_enabled);
  assign irq_out = |(irq_stat & irq_en);

  // ==========================================================
  // read path: data stand only in the cycle after the strobe
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] slot_word;

  always_comb begin
    slot_word = '0;
    slot_word[15:0] = ctl;
    slot_word[BTN_BIT] = flags[EV_BTN];
    slot_word[FAULT_BIT] = flags[EV_FAULT];
    slot_word[LATCH_CHG_BIT] = flags[EV_LATCH];
    slot_word[PRES_CHG_BIT] = flags[EV_PRES];
    slot_word[CMD_BIT] = flags[EV_CMD];
    slot_word[LATCH_STATE_BIT] = latch_state;
    // inverted strap value stands in for the state until the first running edge
    slot_word[PRES_STATE_BIT] = running ? presence_state : ~card_present_strap_in;
    if (!slot_implemented_in) begin
      slot_word[PRES_STATE_BIT] = 1'b1;
    end
    slot_word[LINK_CHG_BIT] = flags[EV_LINK];
    next_rdata = '0;
    if (rd_in) begin
      if (hit(addr_in, SLOT_REG_OFFSET) && downstream_port_in) begin
        next_rdata = slot_word;
      end else if (hit(addr_in, IRQ_STAT_OFFSET)) begin
        next_rdata[NUM_IRQ-1:0] = irq_stat;
      end else if (hit(addr_in, IRQ_EN_OFFSET)) begin
        next_rdata[NUM_IRQ-1:0] = irq_en;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign rdata_out = rdata;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  a_nondown_reads_zero: assert property (
    (rd_in && !downstream_port_in && hit(addr_in, SLOT_REG_OFFSET)) |=> (rdata_out == '0))
    else $error("slot dword visible on a non-downstream port");
  a_button_sets_flag: assert property (
    (attn_button_in && downstream_port_in) |=> flags[EV_BTN])
    else $error("button press not flagged");
  a_button_held: assert property (
    (flags[EV_BTN] && !(slot_wr && wdata_in[BTN_BIT])) |=> flags[EV_BTN])
    else $error("button flag dropped without a clear");
  a_fault_w1c_clears: assert property (
    (slot_wr && wdata_in[FAULT_BIT] && !power_fault_in) |=> !flags[EV_FAULT])
    else $error("power fault flag not cleared by one");
  a_latch_chg_ro: assert property (
    (slot_wr && flags[EV_LATCH]) |=> flags[EV_LATCH])
    else $error("latch change flag cleared by a write");
  a_presence_change: assert property (
    (running && downstream_port_in && (card_present_in != presence_state)) |=> flags[EV_PRES])
    else $error("presence change not flagged");
  a_cmd_done_flag: assert property (
    (cmd_done_in && downstream_port_in) |=> flags[EV_CMD])
    else $error("command completion not flagged");
  a_latch_mirror: assert property (
    (rd_in && hit(addr_in, SLOT_REG_OFFSET) && downstream_port_in)
    |=> (rdata_out[LATCH_STATE_BIT] == $past(latch_state)))
    else $error("latch state does not mirror sensor");
  a_no_slot_present: assert property (
    (rd_in && hit(addr_in, SLOT_REG_OFFSET) && downstream_port_in && !slot_implemented_in)
    |=> rdata_out[PRES_STATE_BIT])
    else $error("presence not one without a slot");
  a_strap_reset: assert property (
    $rose(running) |-> (presence_state == !$past(card_present_strap_in)))
    else $error("presence reset ignores strap");
  a_strap_read: assert property (
    (rd_in && !running && hit(addr_in, SLOT_REG_OFFSET) && downstream_port_in && slot_implemented_in)
    |=> (rdata_out[PRES_STATE_BIT] == !$past(card_present_strap_in)))
    else $error("presence read before start ignores strap");
  a_link_change: assert property (
    (running && downstream_port_in && $changed(link_active_in)) |=> flags[EV_LINK])
    else $error("link change not flagged");
  a_reserved_zero: assert property (
    rd_in |=> (rdata_out[23] == 1'b0) && (rdata_out[31:25] == '0))
    else $error("reserved bits read nonzero");
  a_hp_int_gated: assert property (
    hp_int_out |-> ctl[CTL_HP_INT_EN_BIT] && (|(flags[NUM_IRQ-1:0])))
    else $error("hot-plug interrupt without enable");
  a_cmd_int_gated: assert property (
    (hp_int_out && (flags[NUM_IRQ-1:0] == (5'h01 << EV_CMD))) |-> ctl[CTL_CMD_EN_BIT])
    else $error("command interrupt without its enable");

  c_button_int: cover property (attn_button_in ##1 hp_int_out);
  c_presence_change: cover property (running && (card_present_in != presence_state) ##1 flags[EV_PRES]);
  c_clear_same_cycle: cover property (slot_wr && wdata_in[BTN_BIT] && attn_button_in);
  c_irq_out: cover property ($rose(irq_out));
  c_early_read: cover property (rd_in && !running);

endmodule : hps_slot_status

/* tb/hps_slot_model.sv */
// slot hardware model: button, power fault, command completion, link, presence and latch
`timescale 1ns/10ps
module hps_slot_model (
  // clock
  input wire logic clock_in,
  // requests from the bench: 0 button, 1 fault, 2 command done, 3 link toggle
  input wire logic [3:0] req_in,
  input wire logic card_in,
  input wire logic latch_open_in,
  // slot lines
  output logic attn_button_out = 1'b0,
  output logic power_fault_out = 1'b0,
  output logic cmd_done_out = 1'b0,
  output logic link_active_out = 1'b0,
  output logic card_present_out = 1'b1,
  output logic retention_latch_open_out = 1'b0
);
  // ==========================================================
  // one-cycle event pulses and level lines, all moved on the rising edge
  always @(posedge clock_in) begin
    attn_button_out <= req_in[0];
    power_fault_out <= req_in[1];
    cmd_done_out <= req_in[2];
    if (req_in[3]) begin
      link_active_out <= ~link_active_out;
    end
    card_present_out <= card_in;
    retention_latch_open_out <= latch_open_in;
  end
endmodule : hps_slot_model

/* tb/tb_top.sv */
// self-checking bench for the slot status block
`timescale 1ns/10ps
module tb_top
  import hps_pkg::*;
;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic dsp = 1'b1;
  logic slot_impl = 1'b1;
  logic strap = 1'b0;
  logic hp_int;
  logic irq;
  logic hw_init;
  logic [3:0] req = 4'h0;
  logic card_req = 1'b1;
  logic latch_req = 1'b0;
  logic attn, fault, done, link, card, latch;
  int num_errors = 0;
  int cmp_count = 0;

  hps_slot_model i_model (.clock_in(clock_in), .req_in(req), .card_in(card_req), .latch_open_in(latch_req),
    .attn_button_out(attn), .power_fault_out(fault), .cmd_done_out(done), .link_active_out(link),
    .card_present_out(card), .retention_latch_open_out(latch));

  hps_slot_status i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .downstream_port_in(dsp), .slot_implemented_in(slot_impl),
    .card_present_strap_in(strap), .card_present_in(card), .retention_latch_open_in(latch),
    .attn_button_in(attn), .power_fault_in(fault), .cmd_done_in(done), .link_active_in(link),
    .hp_int_out(hp_int), .irq_out(irq), .hardware_initialized_out(hw_init));

  // ==========================================================
  // clock and common tasks
  initial begin
    forever #20 clock_in = ~clock_in;
  end

  task automatic close_out();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask : wr32

  task automatic rd32(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd32

  task automatic ev(input int i);
    @(posedge clock_in);
    req <= 4'h1 << i;
    @(posedge clock_in);
    req <= 4'h0;
    repeat (3) @(posedge clock_in);
  endtask : ev

  task automatic do_reset(input logic s);
    @(posedge clock_in);
    rst_b_in <= 1'b0;
    strap <= s;
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clock_in);
  endtask : do_reset

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk({31'h0, hw_init}, 32'h1);
    rd32(SLOT_REG_OFFSET, 32'h0140_03c0);
    rd32(12'h0dc, 32'h0);
    wr32(SLOT_REG_OFFSET, 32'h0100_03c0);
    rd32(SLOT_REG_OFFSET, 32'h0040_03c0);
  endtask : t_reset

  task automatic t_events();
    int b[4] = '{16, 17, 20, 24};
    for (int i = 0; i < 4; i++) begin
      ev(i);
      wr32(SLOT_REG_OFFSET, 32'h0000_03c0);
      rd32(SLOT_REG_OFFSET, 32'h0040_03c0 | (32'h1 << b[i]));
      wr32(SLOT_REG_OFFSET, 32'h0000_03c0 | (32'h1 << b[i]));
      rd32(SLOT_REG_OFFSET, 32'h0040_03c0);
    end
  endtask : t_events

  task automatic t_presence_latch();
    card_req <= 1'b0;
    repeat (4) @(posedge clock_in);
    rd32(SLOT_REG_OFFSET, 32'h0008_03c0);
    wr32(SLOT_REG_OFFSET, 32'h0008_03c0);
    card_req <= 1'b1;
    repeat (4) @(posedge clock_in);
    rd32(SLOT_REG_OFFSET, 32'h0048_03c0);
    wr32(SLOT_REG_OFFSET, 32'h0008_03c0);
    latch_req <= 1'b1;
    repeat (4) @(posedge clock_in);
    wr32(SLOT_REG_OFFSET, 32'hff84_03c0);
    rd32(SLOT_REG_OFFSET, 32'h0064_03c0);
    latch_req <= 1'b0;
    repeat (4) @(posedge clock_in);
    rd32(SLOT_REG_OFFSET, 32'h0044_03c0);
  endtask : t_presence_latch

  task automatic t_interrupts();
    wr32(IRQ_CLR_OFFSET, 32'h1f);
    wr32(IRQ_EN_OFFSET, 32'h1);
    wr32(SLOT_REG_OFFSET, 32'h0000_03e1);
    ev(0);
    chk({30'h0, hp_int, irq}, 32'h3);
    rd32(IRQ_STAT_OFFSET, 32'h1);
    wr32(SLOT_REG_OFFSET, 32'h0001_03c1);
    wr32(IRQ_CLR_OFFSET, 32'h1);
    ev(0);
    chk({30'h0, hp_int, irq}, 32'h1);
    wr32(SLOT_REG_OFFSET, 32'h0001_03e0);
    ev(2);
    chk({31'h0, hp_int}, 32'h0);
    wr32(SLOT_REG_OFFSET, 32'h0010_03f0);
    ev(2);
    chk({31'h0, hp_int}, 32'h1);
    wr32(SLOT_REG_OFFSET, 32'h0010_03c0);
    wr32(IRQ_CLR_OFFSET, 32'h1f);
    @(posedge clock_in);
    chk({30'h0, hp_int, irq}, 32'h0);
  endtask : t_interrupts

  task automatic t_port_config();
    card_req <= 1'b0;
    slot_impl <= 1'b0;
    repeat (4) @(posedge clock_in);
    rd32(SLOT_REG_OFFSET, 32'h004c_03c0);
    @(posedge clock_in);
    dsp <= 1'b0;
    rd32(SLOT_REG_OFFSET, 32'h0);
    @(posedge clock_in);
    dsp <= 1'b1;
    slot_impl <= 1'b1;
    do_reset(1'b1);
    rd32(SLOT_REG_OFFSET, 32'h0100_03c0);
    // read taken at the first edge after release, strap low
    @(posedge clock_in);
    rst_b_in <= 1'b0;
    strap <= 1'b0;
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    addr <= SLOT_REG_OFFSET;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    chk(rdata, 32'h0140_03c0);
  endtask : t_port_config

  // ==========================================================
  // main sequence and watchdog
  initial begin
    do_reset(1'b0);
    t_reset();
    t_events();
    t_presence_latch();
    t_interrupts();
    t_port_config();
    close_out();
  end

  initial begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule : tb_top
